// File: inc/fcc_consts.vh
// Constants of the flash control command unit.
`ifndef FCC_CONSTS_VH
`define FCC_CONSTS_VH

// ----------------------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------------------
`define FCC_OP_WEN_CODE    8'h06
`define FCC_OP_WRDIS_CODE  8'h04
`define FCC_OP_CLRST_CODE  8'h30
`define FCC_OP_ECCST_CODE  8'h18
`define FCC_OP_BTRD_CODE   8'h14
`define FCC_OP_BTWR_CODE   8'h15
`define FCC_OP_LPNV_CODE   8'h43
`define FCC_OP_REGWR_CODE  8'h01
`define FCC_OP_BANKA_CODE  8'hb9

// ----------------------------------------------------------------------------
// Bit counts at which a command or its address is complete or its output starts
// ----------------------------------------------------------------------------
`define FCC_CNT_OPC        9'h008
`define FCC_CNT_LPNV       9'h010
`define FCC_CNT_REGWR_S    9'h010
`define FCC_CNT_REGWR_L    9'h018
`define FCC_CNT_BTWR       9'h028
`define FCC_CNT_ECC_ADDR   9'h028
`define FCC_CNT_ECC_OUT    9'h030

// ----------------------------------------------------------------------------
// Status register one fields
// ----------------------------------------------------------------------------
`define FCC_SR_BUSY        0
`define FCC_SR_LATCH       1
`define FCC_SR_EERR        5
`define FCC_SR_PERR        6

// ----------------------------------------------------------------------------
// Boot configuration register layout, register reset values and correction unit step
// ----------------------------------------------------------------------------
`define FCC_BC_EN          0
`define FCC_BC_DLY_LSB     1
`define FCC_BC_DLY_MSB     8
`define FCC_BC_ADR_LSB     9
`define FCC_BC_ADR_MSB     31
`define FCC_BC_RST         32'h00000000
`define FCC_LP_RST         8'h00
`define FCC_ECC_STEP       32'h00000010

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define FCC_CLK_PERIOD_NS  20
`define FCC_NV_WRITE_NS    10000
`define FCC_NV_WRITE_CYC   (`FCC_NV_WRITE_NS / `FCC_CLK_PERIOD_NS)

`endif

// File: hw/fcc_top.v
// Flash control command unit: register commands, correction status, boot read.
//
// Summary of operation
// RQ1 - Write-enable instruction sets the write-enable latch, status bit 1.
// RQ2 - Write-disable instruction clears the write-enable latch.
// RQ3 - Latch commands act only when select rises right after the eighth bit.
// RQ4 - Write-disable is ignored while write-in-progress is set.
// RQ5 - Clear-status clears both fail flags, always accepted, latch untouched.
// RQ6 - Correction status read: unit address, eight dummies, status byte sixteen times.
// RQ7 - Select still low: continue with next unit, sixteen times each.
// RQ8 - Boot-read enabled: after reset, stream code from start address on select.
// RQ9 - Boot output waits the 8-bit start-delay count of clocks.
// RQ10 - Host sends no command during the boot start delay.
// RQ11 - Host limits clock to 50, 133 or 104 MHz by delay and quad.
// RQ12 - Boot start address is a 23-bit field of 512-byte blocks, default zero.
// RQ13 - Boot streams until select rises, then never again until reset.
// RQ14 - Quad bit set: boot code four bits per clock, else serial.
// RQ15 - Boot register read: low byte first, MSB first, repeating every 32 clocks.
// RQ16 - Boot register write needs latch and select rising right after bit 40.
// RQ17 - Boot register write sets erase or program fail flag by failing phase.
// RQ18 - Valid boot write runs self-timed with write-in-progress, then clears latch.
// RQ19 - Learn pattern program needs latch and select rising right after eight data bits.
// RQ20 - Learn pattern program holds write-in-progress, flags program fail, clears latch.
// RQ21 - Quad bit set disables write-protect pin hardware protection.
// RQ22 - Register write right after bank access loads the bank register.
// RQ23 - Any other command or select cycle ends bank access.
// RQ24 - Writes without the write-enable latch are rejected with no effect.
`timescale 1ns/1ps
`include "fcc_consts.vh"
`default_nettype none

module fcc_top (
  // System clock and reset
  input  wire        CLOCK,
  input  wire        RESETN,
  // Serial pins from the host
  input  wire        CS_N,
  input  wire        SCK,
  input  wire        SI,
  input  wire        WP_N,
  // Data lines driven by the device
  output wire [3:0]  IO_OUT,
  output wire [3:0]  IO_OE,
  // Configuration and array side
  input  wire        QUAD_EN,
  input  wire        ERASE_FAIL,
  input  wire        PROGRAM_FAIL,
  output wire [31:0] ECC_ADDR,
  input  wire [7:0]  ECC_STATUS,
  output wire [31:0] BOOT_ADDR,
  input  wire [7:0]  BOOT_DATA,
  // Register contents and write strobes
  output wire [7:0]  STATUS,
  output wire [31:0] BOOT_CFG,
  output wire [7:0]  LEARN_PATTERN,
  output wire        HW_PROTECT,
  output reg         REG_WR_STATUS,
  output reg         REG_WR_BANK,
  output wire [15:0] REG_WR_DATA
);

  // --------------------------------------------------------------------------
  // Modes of a select cycle (one-hot)
  // --------------------------------------------------------------------------
  localparam [4:0] M_IDLE = 5'h01;
  localparam [4:0] M_CMD  = 5'h02;
  localparam [4:0] M_ECC  = 5'h04;
  localparam [4:0] M_BTRD = 5'h08;
  localparam [4:0] M_BOOT = 5'h10;
  localparam [31:0] NV_CYC_W = `FCC_NV_WRITE_CYC;
  localparam [9:0]  NV_CYC   = NV_CYC_W[9:0];

  reg  [2:0]  sck_s_r, csn_s_r, si_s_r, wp_s_r;
  reg         sck_q_r, csn_q_r, wp_q_r;
  reg  [4:0]  mode_r;
  reg  [31:0] sr_r;
  reg  [8:0]  tot_r;
  reg  [7:0]  cmd_r;
  reg  [7:0]  out_cnt_r;
  reg         out_en_r, out_quad_r, hold_r;
  reg  [3:0]  io_out_r;
  reg  [31:0] ecc_addr_r, boot_addr_r;
  reg         wlatch_r, eerr_r, perr_r, bank_r, boot_armed_r;
  reg  [9:0]  busy_cnt_r;
  reg         op_btwr_r;
  reg  [31:0] pend_r;
  // Non-volatile contents start blank and are not touched by a reset.
  reg  [31:0] boot_cfg_r = `FCC_BC_RST;
  reg  [7:0]  learn_r    = `FCC_LP_RST;
  reg  [15:0] regwr_r;

  // --------------------------------------------------------------------------
  // Pin filtering: a level counts once the second and third stage agree.
  // --------------------------------------------------------------------------
  wire       sck_ok   = (sck_s_r[1] == sck_s_r[2]);
  wire       csn_ok   = (csn_s_r[1] == csn_s_r[2]);
  wire       sck_rise = sck_ok & sck_s_r[2] & ~sck_q_r & ~csn_q_r;
  wire       sck_fall = sck_ok & ~sck_s_r[2] & sck_q_r & ~csn_q_r;
  wire       cs_fall  = csn_ok & ~csn_s_r[2] & csn_q_r;
  wire       cs_rise  = csn_ok & csn_s_r[2] & ~csn_q_r;
  wire       busy     = (busy_cnt_r != 10'h000);
  wire [7:0] dly      = boot_cfg_r[`FCC_BC_DLY_MSB:`FCC_BC_DLY_LSB];
  wire       boot_go  = boot_armed_r & boot_cfg_r[`FCC_BC_EN];

  wire [31:0] sr_nxt  = {sr_r[30:0], si_s_r[2]};
  wire [8:0]  tot_nxt = (tot_r == 9'h1ff) ? tot_r : tot_r + 9'h001;
  wire        opc_end = sck_rise & (mode_r == M_CMD) & (tot_nxt == `FCC_CNT_OPC);

  // Events that begin an output stream.
  wire st_btrd = opc_end & (sr_nxt[7:0] == `FCC_OP_BTRD_CODE);
  wire st_ecc  = sck_rise & (mode_r == M_ECC) & (tot_nxt == `FCC_CNT_ECC_OUT);
  wire st_bt0  = cs_fall & boot_go & (dly == 8'h00);
  wire st_btn  = sck_rise & (mode_r == M_BOOT) & (dly != 8'h00) &
                 (tot_nxt == {1'b0, dly}); // [RQ9]
  wire start   = st_btrd | st_ecc | st_bt0 | st_btn;
  wire emit    = start | (sck_fall & out_en_r & ~hold_r);

  // --------------------------------------------------------------------------
  // Element being emitted: its index, source byte and line values.
  // --------------------------------------------------------------------------
  reg  [4:0] em_mode;
  reg  [7:0] em_n;
  reg  [7:0] em_byte;
  reg        em_quad;
  reg  [3:0] em_val;
  reg        em_last;

  always @* begin
    em_mode = st_btrd ? M_BTRD : ((st_bt0 | st_btn) ? M_BOOT : mode_r);
    em_n    = start ? 8'h00 : out_cnt_r + 8'h01;
    em_quad = start ? (QUAD_EN & (em_mode == M_BOOT)) : out_quad_r; // [RQ14]
    case (em_mode)
      M_BTRD:  em_byte = boot_cfg_r[{em_n[4:3], 3'h0} +: 8]; // [RQ15]
      M_ECC:   em_byte = ECC_STATUS;                          // [RQ6]
      M_BOOT:  em_byte = BOOT_DATA;                           // [RQ8]
      default: em_byte = 8'h00;
    endcase
    if (em_quad) begin
      em_val  = em_n[0] ? em_byte[3:0] : em_byte[7:4];
      em_last = em_n[0];
    end else begin
      em_val  = {2'b00, em_byte[~em_n[2:0]], 1'b0};
      em_last = (em_n[2:0] == 3'h7);
    end
  end

  // --------------------------------------------------------------------------
  // Input synchronisers and filtered levels.
  // --------------------------------------------------------------------------
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      sck_s_r <= 3'h0;
      csn_s_r <= 3'h7;
      si_s_r  <= 3'h0;
      wp_s_r  <= 3'h7;
      sck_q_r <= 1'b0;
      csn_q_r <= 1'b1;
      wp_q_r  <= 1'b1;
    end else begin
      sck_s_r <= {sck_s_r[1:0], SCK};
      csn_s_r <= {csn_s_r[1:0], CS_N};
      si_s_r  <= {si_s_r[1:0], SI};
      wp_s_r  <= {wp_s_r[1:0], WP_N};
      if (sck_ok)
        sck_q_r <= sck_s_r[2];
      if (csn_ok)
        csn_q_r <= csn_s_r[2];
      if (wp_s_r[1] == wp_s_r[2])
        wp_q_r <= wp_s_r[2];
    end
  end

  // --------------------------------------------------------------------------
  // Serial framing, decode and output streaming.
  // --------------------------------------------------------------------------
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      mode_r      <= M_IDLE;
      sr_r        <= 32'h00000000;
      tot_r       <= 9'h000;
      cmd_r       <= 8'h00;
      out_cnt_r   <= 8'h00;
      out_en_r    <= 1'b0;
      out_quad_r  <= 1'b0;
      hold_r      <= 1'b0;
      io_out_r    <= 4'h0;
      ecc_addr_r  <= 32'h00000000;
      boot_addr_r <= 32'h00000000;
    end else begin
      if (cs_fall) begin
        // A boot stream replaces opcode parsing on the first cycle. [RQ8]
        mode_r      <= boot_go ? M_BOOT : M_CMD;
        tot_r       <= 9'h000;
        out_en_r    <= 1'b0;
        boot_addr_r <= {boot_cfg_r[`FCC_BC_ADR_MSB:`FCC_BC_ADR_LSB], 9'h000}; // [RQ12]
      end else if (cs_rise) begin
        mode_r   <= M_IDLE;
        out_en_r <= 1'b0; // [RQ13]
      end else if (sck_rise) begin
        sr_r  <= sr_nxt;
        tot_r <= tot_nxt;
        if (opc_end) begin
          cmd_r <= sr_nxt[7:0];
          if (sr_nxt[7:0] == `FCC_OP_ECCST_CODE)
            mode_r <= M_ECC;
          else if (sr_nxt[7:0] == `FCC_OP_BTRD_CODE)
            mode_r <= M_BTRD;
        end
        // Unit address with its low four bits forced to zero. [RQ6]
        if (mode_r == M_ECC && tot_nxt == `FCC_CNT_ECC_ADDR)
          ecc_addr_r <= {sr_nxt[31:4], 4'h0};
      end
      if (emit && !cs_rise) begin
        out_en_r   <= 1'b1;
        out_cnt_r  <= em_n;
        out_quad_r <= em_quad;
        io_out_r   <= em_val;
        // Boot address steps once per finished byte.
        if (em_mode == M_BOOT && em_last)
          boot_addr_r <= boot_addr_r + 32'h00000001;
        // After sixteen copies move on to the next unit. [RQ7]
        if (em_mode == M_ECC && em_n[6:0] == 7'h7f)
          ecc_addr_r <= ecc_addr_r + `FCC_ECC_STEP;
      end
      // A stream started on a rise keeps its first element over the next
      // fall, otherwise the host would never sample that element.
      if (cs_fall || cs_rise)
        hold_r <= 1'b0;
      else if (st_btrd || st_ecc || st_btn)
        hold_r <= 1'b1;
      else if (sck_fall)
        hold_r <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Command execution at select rise and self-timed writes.
  // Flags set by a finishing write win over a clear in the same cycle.
  // --------------------------------------------------------------------------
  wire ex     = cs_rise & (mode_r == M_CMD);
  wire ex8    = ex & (tot_r == `FCC_CNT_OPC); // [RQ3]
  wire ex_wen = ex8 & (cmd_r == `FCC_OP_WEN_CODE) & ~busy;
  wire ex_wds = ex8 & (cmd_r == `FCC_OP_WRDIS_CODE) & ~busy; // [RQ4]
  wire ex_clr = ex8 & (cmd_r == `FCC_OP_CLRST_CODE);
  wire ex_bnk = ex8 & (cmd_r == `FCC_OP_BANKA_CODE);
  wire ex_btw = ex & (cmd_r == `FCC_OP_BTWR_CODE) & (tot_r == `FCC_CNT_BTWR) &
                wlatch_r & ~busy; // [RQ16] [RQ24]
  wire ex_lpn = ex & (cmd_r == `FCC_OP_LPNV_CODE) & (tot_r == `FCC_CNT_LPNV) &
                wlatch_r & ~busy; // [RQ19] [RQ24]
  wire ex_rw  = ex & (cmd_r == `FCC_OP_REGWR_CODE) & wlatch_r & ~busy &
                ((tot_r == `FCC_CNT_REGWR_S) | (tot_r == `FCC_CNT_REGWR_L));
  wire done   = (busy_cnt_r == 10'h001);

  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      wlatch_r      <= 1'b0;
      eerr_r        <= 1'b0;
      perr_r        <= 1'b0;
      bank_r        <= 1'b0;
      boot_armed_r  <= 1'b1;
      busy_cnt_r    <= 10'h000;
      op_btwr_r     <= 1'b0;
      pend_r        <= 32'h00000000;
      regwr_r       <= 16'h0000;
      REG_WR_STATUS <= 1'b0;
      REG_WR_BANK   <= 1'b0;
    end else begin
      REG_WR_STATUS <= 1'b0;
      REG_WR_BANK   <= 1'b0;
      if (cs_rise) begin
        boot_armed_r <= 1'b0;   // [RQ13]
        bank_r       <= ex_bnk; // [RQ23]
      end
      if (ex_wen)
        wlatch_r <= 1'b1; // [RQ1]
      if (ex_wds)
        wlatch_r <= 1'b0; // [RQ2]
      if (ex_clr) begin
        eerr_r <= 1'b0; // [RQ5]
        perr_r <= 1'b0; // [RQ5]
      end
      if (ex_rw) begin
        regwr_r <= (tot_r == `FCC_CNT_REGWR_S) ? {8'h00, sr_r[7:0]} : sr_r[15:0];
        // Directly after bank access the write goes to the bank register.
        REG_WR_BANK   <= bank_r;  // [RQ22]
        REG_WR_STATUS <= ~bank_r; // [RQ23]
      end
      if (ex_btw || ex_lpn) begin
        busy_cnt_r <= NV_CYC; // [RQ18] [RQ20]
        op_btwr_r  <= ex_btw;
        // Boot data arrives low byte first; reassemble the word.
        pend_r <= ex_btw ? {sr_r[7:0], sr_r[15:8], sr_r[23:16], sr_r[31:24]}
                         : {24'h000000, sr_r[7:0]};
      end else if (busy) begin
        busy_cnt_r <= busy_cnt_r - 10'h001;
      end
      if (done) begin
        wlatch_r <= 1'b0; // [RQ18] [RQ20]
        if (op_btwr_r) begin
          // The erase phase runs first, so its failure is reported alone.
          if (ERASE_FAIL)
            eerr_r <= 1'b1; // [RQ17]
          else if (PROGRAM_FAIL)
            perr_r <= 1'b1; // [RQ17]
        end else if (PROGRAM_FAIL) begin
          perr_r <= 1'b1; // [RQ20]
        end
      end
    end
  end

  // Non-volatile registers load only on a clean finish and keep their value
  // through a hardware reset, so the reset that arms a boot still sees it. [RQ8]
  wire nv_ok = done & ~PROGRAM_FAIL & ~(op_btwr_r & ERASE_FAIL);
  always @(posedge CLOCK) begin
    if (nv_ok && op_btwr_r)
      boot_cfg_r <= pend_r;
    if (nv_ok && !op_btwr_r)
      learn_r <= pend_r[7:0];
  end

  // --------------------------------------------------------------------------
  // Outputs.
  // --------------------------------------------------------------------------
  assign IO_OUT        = io_out_r;
  assign IO_OE         = out_en_r ? (out_quad_r ? 4'hf : 4'h2) : 4'h0; // [RQ14]
  assign ECC_ADDR      = ecc_addr_r;
  assign BOOT_ADDR     = boot_addr_r;
  assign STATUS        = {1'b0, perr_r, eerr_r, 3'h0, wlatch_r, busy};
  assign BOOT_CFG      = boot_cfg_r;
  assign LEARN_PATTERN = learn_r;
  assign REG_WR_DATA   = regwr_r;
  // The protect pin doubles as data line two in quad mode. [RQ21]
  assign HW_PROTECT    = ~QUAD_EN & ~wp_q_r;

endmodule // fcc_top

`default_nettype wire

// File: tb/fcc_assertions.sv
// Port checker of the flash control command unit.
`timescale 1ns/1ps
`default_nettype none
module fcc_assertions (
  // Clock and reset
  input wire logic        CLOCK,
  input wire logic        RESETN,
  // Observed ports
  input wire logic        CS_N,
  input wire logic        QUAD_EN,
  input wire logic [3:0]  IO_OE,
  input wire logic [31:0] ECC_ADDR,
  input wire logic [7:0]  STATUS,
  input wire logic        HW_PROTECT,
  input wire logic        REG_WR_STATUS,
  input wire logic        REG_WR_BANK
);
  // ----
  // Properties
  // ----
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);
  // Six idle cycles cover the select filter plus the output register.
  property p_oe_idle; CS_N [*6] |-> IO_OE == 4'h0; endproperty
  property p_oe_mode; IO_OE == 4'h0 || IO_OE == 4'h2 || (IO_OE == 4'hf && QUAD_EN); endproperty
  property p_prot_quad; QUAD_EN |-> !HW_PROTECT; endproperty
  property p_busy_run; $rose(STATUS[0]) |-> STATUS[0] [*8]; endproperty
  property p_latch_end; $fell(STATUS[0]) |-> !STATUS[1]; endproperty
  property p_latch_cs; $rose(STATUS[1]) |-> CS_N; endproperty
  // A busy unit ignores both latch commands, so the latch cannot move.
  property p_latch_busy; STATUS[0] && $past(STATUS[0]) |-> $stable(STATUS[1]); endproperty
  property p_err_end; $rose(STATUS[6]) || $rose(STATUS[5]) |-> $past(STATUS[0]); endproperty
  property p_wr_once;
    REG_WR_STATUS || REG_WR_BANK |-> CS_N && !(REG_WR_STATUS && REG_WR_BANK) ##1
      !REG_WR_STATUS && !REG_WR_BANK;
  endproperty
  property p_ecc_unit; ECC_ADDR[3:0] == 4'h0; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("outputs driven while deselected");
  a_oe_mode: assert property (p_oe_mode) else $error("bad data line enables");
  a_prot_quad: assert property (p_prot_quad) else $error("protection in quad mode");
  a_busy_run: assert property (p_busy_run) else $error("busy too short");
  a_latch_end: assert property (p_latch_end) else $error("latch kept after write");
  a_latch_cs: assert property (p_latch_cs) else $error("latch set while selected");
  a_latch_busy: assert property (p_latch_busy) else $error("latch moved while busy");
  a_err_end: assert property (p_err_end) else $error("fail flag while idle");
  a_wr_once: assert property (p_wr_once) else $error("bad register strobe");
  a_ecc_unit: assert property (p_ecc_unit) else $error("unaligned unit address");
  c_busy: cover property ($rose(STATUS[0]));
  c_bank: cover property (REG_WR_BANK);
  c_serial: cover property (IO_OE == 4'h2);
  c_quad: cover property (IO_OE == 4'hf);
endmodule // fcc_assertions
bind fcc_top fcc_assertions chk_u (
  .CLOCK(CLOCK), .RESETN(RESETN), .CS_N(CS_N), .QUAD_EN(QUAD_EN), .IO_OE(IO_OE),
  .ECC_ADDR(ECC_ADDR), .STATUS(STATUS), .HW_PROTECT(HW_PROTECT),
  .REG_WR_STATUS(REG_WR_STATUS), .REG_WR_BANK(REG_WR_BANK)
);
`default_nettype wire

// File: tb/fcc_host_model.sv
// Behavioural host controller that frames serial transfers.
`timescale 1ns/1ps
`default_nettype none
module fcc_host_model #(
  parameter int HALF = 6
) (
  // Pacing clock and device data lines
  input  wire logic       clk,
  input  wire logic [3:0] io_out,
  // Serial pins to the device
  output logic            cs_n,
  output logic            sck,
  output logic            si
);
  // ----
  // Frame driver
  // ----
  // Each clock level spans HALF system clocks: slow, but the filters settle.
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  // Sends n bits MSB first and samples the data lines before each rise.
  task automatic xfer(input int n, input logic [191:0] d, input bit q,
                      output logic [191:0] r);
    int k;
    r = '0;
    @(negedge clk);
    cs_n = 1'b0;
    for (k = n - 1; k >= 0; k--) begin
      si = d[k];
      repeat (HALF) @(negedge clk);
      r = q ? {r[187:0], io_out} : {r[190:0], io_out[1]};
      sck = 1'b1;
      repeat (HALF) @(negedge clk);
      sck = 1'b0;
    end
    repeat (HALF) @(negedge clk);
    cs_n = 1'b1;
    si = ~si;
    repeat (HALF) @(negedge clk);
  endtask
endmodule // fcc_host_model
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench of the flash control command unit.
`timescale 1ns/1ps
`default_nettype none
`include "fcc_consts.vh"
module tb;
  // ----
  // Design, host and array contents
  // ----
  logic         clk, rst_n, wp_n, quad_en, erase_fail, program_fail;
  wire          cs_n, sck, si, hw_protect, wr_status, wr_bank;
  wire  [3:0]   io_out, io_oe;
  wire  [31:0]  ecc_addr, boot_addr, boot_cfg;
  wire  [7:0]   status, learn;
  wire  [15:0]  wr_data;
  wire  [7:0]   ecc_status = ecc_addr[11:4] ^ 8'h5a;
  wire  [7:0]   boot_data = boot_addr[7:0] ^ 8'h3c;
  int           bad_count = 0, cmp_count = 0, bank_n = 0, stat_n = 0, i;
  logic [191:0] r;
  // Rows: bit count, frame, {erase fail, program fail}, status once idle.
  logic [71:0]  rows [15] = '{
    {8'h08, 48'h06, 8'h00, 8'h02}, {8'h08, 48'h04, 8'h00, 8'h00},
    {8'h09, 48'h0c, 8'h00, 8'h00}, {8'h10, 48'h43a5, 8'h00, 8'h00},
    {8'h08, 48'h06, 8'h00, 8'h02}, {8'h10, 48'h433c, 8'h01, 8'h40},
    {8'h08, 48'h30, 8'h00, 8'h00}, {8'h08, 48'h06, 8'h00, 8'h02},
    {8'h08, 48'h30, 8'h00, 8'h02}, {8'h10, 48'h43a5, 8'h00, 8'h00},
    {8'h08, 48'h06, 8'h00, 8'h02}, {8'h28, 48'h1500000000, 8'h02, 8'h20},
    {8'h08, 48'h30, 8'h00, 8'h00}, {8'h08, 48'h06, 8'h00, 8'h02},
    {8'h28, 48'h1505020000, 8'h00, 8'h00}};
  fcc_top dut_u (
    .CLOCK(clk), .RESETN(rst_n), .CS_N(cs_n), .SCK(sck), .SI(si), .WP_N(wp_n),
    .IO_OUT(io_out), .IO_OE(io_oe), .QUAD_EN(quad_en), .ERASE_FAIL(erase_fail),
    .PROGRAM_FAIL(program_fail), .ECC_ADDR(ecc_addr), .ECC_STATUS(ecc_status),
    .BOOT_ADDR(boot_addr), .BOOT_DATA(boot_data), .STATUS(status), .BOOT_CFG(boot_cfg),
    .LEARN_PATTERN(learn), .HW_PROTECT(hw_protect), .REG_WR_STATUS(wr_status),
    .REG_WR_BANK(wr_bank), .REG_WR_DATA(wr_data)
  );
  fcc_host_model hst_u (.clk(clk), .io_out(io_out), .cs_n(cs_n), .sck(sck), .si(si));
  // ----
  // Clock, strobe counters and tasks
  // ----
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Strobes last one cycle, so counting them shows which register was loaded.
  always @(posedge clk) begin
    bank_n <= bank_n + int'(wr_bank === 1'b1);
    stat_n <= stat_n + int'(wr_status === 1'b1);
  end
  task automatic chk(input logic [191:0] got, input logic [191:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // A self-timed write is bounded by its nominal length plus margin.
  task automatic wait_idle();
    int k;
    for (k = 0; k < `FCC_NV_WRITE_CYC + 50 && status[0] !== 1'b0; k++) @(negedge clk);
    if (status[0] !== 1'b0) begin
      bad_count++;
      $display("[FAIL] %0t busy never ended", $time);
      report_and_stop();
    end
  endtask
  // A hardware reset in mid-run, then time for the pin filters to fill.
  task automatic pulse_reset();
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  task automatic send(input int n, input logic [191:0] d);
    hst_u.xfer(n, d, 1'b0, r);
    wait_idle();
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    quad_en = 1'b0;
    erase_fail = 1'b0;
    program_fail = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk({status, boot_cfg, learn, io_oe, hw_protect}, 61'h0);
    $display("test reset done");
    for (i = 0; i < 15; i++) begin
      erase_fail = rows[i][9];
      program_fail = rows[i][8];
      send(int'(rows[i][71:64]), 192'(rows[i][63:16]));
      chk(status, rows[i][7:0]);
    end
    chk(boot_cfg, 32'h00000205);
    $display("test table done");
    pulse_reset();
    chk({status, boot_cfg}, {8'h00, 32'h00000205});
    hst_u.xfer(18, 192'h0, 1'b0, r);
    chk(r[15:0], 16'h3c3d);
    hst_u.xfer(72, {8'h14, 64'h0}, 1'b0, r);
    chk(r[63:0], 64'h0502000005020000);
    $display("test boot done");
    hst_u.xfer(184, {48'h180000012000, 136'h0}, 1'b0, r);
    chk(r[135:0], {{16{8'h48}}, 8'h49});
    $display("test correction status done");
    send(8, 192'h06);
    hst_u.xfer(16, 192'h4377, 1'b0, r);
    hst_u.xfer(8, 192'h04, 1'b0, r);
    chk(status, 8'h03);
    wait_idle();
    chk(learn, 8'h77);
    $display("test busy done");
    send(8, 192'h06);
    send(8, 192'hb9);
    send(24, 192'h01abcd);
    send(8, 192'hb9);
    send(8, 192'h06);
    send(24, 192'h011234);
    chk(bank_n, 1);
    chk(stat_n, 1);
    chk(wr_data, 16'h1234);
    $display("test bank done");
    wp_n = 1'b0;
    repeat (6) @(negedge clk);
    chk(hw_protect, 1'b1);
    quad_en = 1'b1;
    @(negedge clk);
    chk(hw_protect, 1'b0);
    $display("test protect done");
    pulse_reset();
    hst_u.xfer(6, 192'h0, 1'b1, r);
    chk(r[15:0], 16'h3c3d);
    $display("test quad boot done");
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
